// ===== src/lpm_params.svh
// constants for the pointer-load / register-move decoder
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define LPM_OFS_CTRL    8'h00
`define LPM_OFS_STATUS  8'h04
`define LPM_OFS_INSTR   8'h08
`define LPM_OFS_WREG    8'h0C
`define LPM_OFS_BANK    8'h10
`define LPM_OFS_PTR0    8'h14
`define LPM_OFS_PTR1    8'h18
`define LPM_OFS_PTR2    8'h1C
`define LPM_OFS_MADDR   8'h20
`define LPM_OFS_MDATA   8'h24

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define LPM_CTRL_EXT_BIT   0
`define LPM_STAT_BUSY_BIT  0
`define LPM_STAT_WAIT_BIT  1
`define LPM_STAT_Z_BIT     2
`define LPM_STAT_N_BIT     3

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define LPM_WREG_RST   8'h00
`define LPM_BANK_RST   6'h00
`define LPM_PTR_RST    14'h0000
`define LPM_INSTR_RST  16'h0000
`define LPM_MADDR_RST  14'h0000

// ------------------------------------------------------------------
// opcodes and addressing
// ------------------------------------------------------------------
`define LPM_OP_MOVE      6'h14
`define LPM_OP_LOAD_POINTER_LITERAL      10'h3B8
`define LPM_PTR_BAD_IDX  2'h3
`define LPM_ACC_SPLIT    8'h60
`define LPM_ILO_MAX      8'h5F
`define LPM_ACC_HI_BANK  6'h3F

`endif

// ===== src/lpm_pkg.sv
// types shared by the pointer-load / register-move decoder
package lpm_pkg;

  // ------------------------------------------------------------------
  // execution state, gray along idle-exec-wait-exec2
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_EXEC  = 2'h1,
    ST_WAIT2 = 2'h3,
    ST_EXEC2 = 2'h2
  } lpm_state_e;

  // four phases of one instruction cycle
  typedef enum logic [1:0] {
    Q1 = 2'h0,
    Q2 = 2'h1,
    Q3 = 2'h3,
    Q4 = 2'h2
  } lpm_qph_e;

  // ------------------------------------------------------------------
  // decoded instruction fields
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       is_move;
    logic       is_load_pointer_literal;
    logic       dst;
    logic       acc;
    logic [7:0] f;
    logic [1:0] idx;
    logic [3:0] khi;
  } lpm_dec_s;

  typedef logic [13:0] lpm_ptr_t;

endpackage

// ===== src/lpm_qphase.sv
// four-phase instruction cycle sequencer
`timescale 1ns/10ps
module lpm_qphase (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             run_i,
  // phase
  output lpm_pkg::lpm_qph_e     ph_o
);

  lpm_pkg::lpm_qph_e ph_q;
  lpm_pkg::lpm_qph_e ph_d;

  // held at the first phase while idle so a new cycle always starts aligned
  always_comb begin
    ph_d = lpm_pkg::Q1;
    if (run_i) begin
      case (ph_q)
        lpm_pkg::Q1: ph_d = lpm_pkg::Q2;
        lpm_pkg::Q2: ph_d = lpm_pkg::Q3;
        lpm_pkg::Q3: ph_d = lpm_pkg::Q4;
        lpm_pkg::Q4: ph_d = lpm_pkg::Q1;
        default:     ph_d = lpm_pkg::Q1;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q <= lpm_pkg::Q1;
    end else begin
      ph_q <= ph_d;
    end
  end

  assign ph_o = ph_q;

endmodule

// ===== src/lpm_decode_top.sv
// pointer-load and register-move executor with a wishbone register port
// Function
// - pointer load writes 14-bit literal, index 0..2
// - two words: bits 13:10 first, 9:0 second
// - move reads register, writes unchanged value, one cycle
// - dest bit 0 to working, 1 back
// - access bit 0 access bank, 1 uses bank
// - extended, access 0, f<=95: indexed literal offset
`timescale 1ns/10ps
`include "lpm_params.svh"
module lpm_decode_top #(
  parameter int AW = 14
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  lpm_pkg::lpm_state_e           st_q, st_d;
  lpm_pkg::lpm_qph_e             ph;
  lpm_pkg::lpm_dec_s             dec_q, dec_d, dec_now;
  logic [15:0]                   instr_q, instr_d;
  logic [7:0]                    rd_q, rd_d, res_q, res_d, w_q, w_d;
  logic                          n_q, n_d, z_q, z_d, ext_q, ext_d;
  logic [2:0][13:0]              fsr_q, fsr_d;
  logic [5:0]                    bsr_q, bsr_d;
  logic [13:0]                   maddr_q, maddr_d;
  logic                          ack_q, ack_d;
  logic [31:0]                   dat_q, dat_d, bus_rd, wv;
  logic                          bus_wr, mem_we;
  lpm_pkg::lpm_ptr_t             ea_w, mem_wa;
  logic [7:0]                    mem_wd;
  logic [7:0]                    dmem [0:(2**AW)-1];

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic lpm_pkg::lpm_dec_s decode(input logic [15:0] iw);
    lpm_pkg::lpm_dec_s d;
    d.is_move = (iw[15:10] == `LPM_OP_MOVE);
    d.is_load_pointer_literal = (iw[15:6] == `LPM_OP_LOAD_POINTER_LITERAL);
    d.dst     = iw[9];
    d.acc     = iw[8];
    d.f       = iw[7:0];
    d.idx     = iw[5:4];
    d.khi     = iw[3:0];
    return d;
  endfunction

  function automatic lpm_pkg::lpm_ptr_t eff_addr(input lpm_pkg::lpm_dec_s d, input logic ext,
                                                input logic [5:0] bank_select_register, input logic [13:0] p2);
    lpm_pkg::lpm_ptr_t a;
    if (!d.acc && ext && (d.f <= `LPM_ILO_MAX)) begin
      a = p2 + {6'h00, d.f};
    end else if (!d.acc) begin
      a = (d.f < `LPM_ACC_SPLIT) ? {6'h00, d.f} : {`LPM_ACC_HI_BANK, d.f};
    end else begin
      a = {bank_select_register, d.f};
    end
    return a;
  endfunction

  // byte-lane merge so partial writes keep untouched lanes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  lpm_qphase u_qphase (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .run_i ((st_q == lpm_pkg::ST_EXEC) || (st_q == lpm_pkg::ST_EXEC2)),
    .ph_o  (ph)
  );

  assign dec_now = decode(instr_q);
  assign ea_w    = eff_addr(dec_q, ext_q, bsr_q, fsr_q[2]);

  // ------------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------------
  always_comb begin
    bus_rd = 32'h0000_0000;
    case (adr_i)
      `LPM_OFS_CTRL:   bus_rd[`LPM_CTRL_EXT_BIT] = ext_q;
      `LPM_OFS_STATUS: begin
        bus_rd[`LPM_STAT_BUSY_BIT] = (st_q != lpm_pkg::ST_IDLE);
        bus_rd[`LPM_STAT_WAIT_BIT] = (st_q == lpm_pkg::ST_WAIT2);
        bus_rd[`LPM_STAT_Z_BIT]    = z_q;
        bus_rd[`LPM_STAT_N_BIT]    = n_q;
      end
      `LPM_OFS_INSTR:  bus_rd[15:0] = instr_q;
      `LPM_OFS_WREG:   bus_rd[7:0]  = w_q;
      `LPM_OFS_BANK:   bus_rd[5:0]  = bsr_q;
      `LPM_OFS_PTR0:   bus_rd[13:0] = fsr_q[0];
      `LPM_OFS_PTR1:   bus_rd[13:0] = fsr_q[1];
      `LPM_OFS_PTR2:   bus_rd[13:0] = fsr_q[2];
      `LPM_OFS_MADDR:  bus_rd[13:0] = maddr_q;
      `LPM_OFS_MDATA:  bus_rd[7:0]  = dmem[maddr_q[AW-1:0]];
      default:         bus_rd = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // next state: bus writes, then execution (execution wins a collision)
  // ------------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    dec_d   = dec_q;
    instr_d = instr_q;
    rd_d    = rd_q;
    res_d   = res_q;
    w_d     = w_q;
    n_d     = n_q;
    z_d     = z_q;
    ext_d   = ext_q;
    fsr_d   = fsr_q;
    bsr_d   = bsr_q;
    maddr_d = maddr_q;
    mem_we  = 1'b0;
    mem_wa  = ea_w;
    mem_wd  = res_q;
    ack_d   = cyc_i & stb_i & ~ack_q;
    dat_d   = ack_d ? bus_rd : dat_q;
    wv      = be_merge(bus_rd, dat_i, sel_i);
    bus_wr  = cyc_i & stb_i & we_i & ack_q;
    if (bus_wr) begin
      case (adr_i)
        `LPM_OFS_CTRL:  ext_d   = wv[`LPM_CTRL_EXT_BIT];
        `LPM_OFS_WREG:  w_d     = wv[7:0];
        `LPM_OFS_BANK:  bsr_d   = wv[5:0];
        `LPM_OFS_MADDR: maddr_d = wv[13:0];
        `LPM_OFS_MDATA: begin
          // refused while an instruction owns the write port
          if (st_q == lpm_pkg::ST_IDLE || st_q == lpm_pkg::ST_WAIT2) begin
            mem_we = 1'b1;
            mem_wa = maddr_q;
            mem_wd = wv[7:0];
          end
        end
        `LPM_OFS_INSTR: begin
          if (st_q == lpm_pkg::ST_IDLE) begin
            instr_d = wv[15:0];
            st_d    = lpm_pkg::ST_EXEC;
          end else if (st_q == lpm_pkg::ST_WAIT2) begin
            instr_d = wv[15:0];
            st_d    = lpm_pkg::ST_EXEC2;
          end
        end
        default: ;
      endcase
    end
    case (st_q)
      lpm_pkg::ST_EXEC: begin
        case (ph)
          lpm_pkg::Q1: dec_d = dec_now;
          lpm_pkg::Q2: rd_d  = dmem[ea_w[AW-1:0]];
          lpm_pkg::Q3: res_d = rd_q;
          lpm_pkg::Q4: begin
            st_d = lpm_pkg::ST_IDLE;
            if (dec_q.is_move) begin
              n_d = res_q[7];
              z_d = (res_q == 8'h00);
              if (dec_q.dst) begin
                mem_we = 1'b1;
                mem_wa = ea_w;
                mem_wd = res_q;
              end else begin
                w_d = res_q;
              end
            end else if (dec_q.is_load_pointer_literal) begin
              st_d = lpm_pkg::ST_WAIT2;
              if (dec_q.idx != `LPM_PTR_BAD_IDX) begin
                fsr_d[dec_q.idx][13:10] = dec_q.khi;
              end
            end
          end
          default: ;
        endcase
      end
      lpm_pkg::ST_EXEC2: begin
        if (ph == lpm_pkg::Q4) begin
          st_d = lpm_pkg::ST_IDLE;
          if (dec_q.idx != `LPM_PTR_BAD_IDX) begin
            fsr_d[dec_q.idx][9:0] = instr_q[9:0];
          end
        end
      end
      default: ;
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= lpm_pkg::ST_IDLE;
      dec_q   <= '0;
      instr_q <= `LPM_INSTR_RST;
      rd_q    <= 8'h00;
      res_q   <= 8'h00;
      w_q     <= `LPM_WREG_RST;
      n_q     <= 1'b0;
      z_q     <= 1'b0;
      ext_q   <= 1'b0;
      fsr_q   <= {3{`LPM_PTR_RST}};
      bsr_q   <= `LPM_BANK_RST;
      maddr_q <= `LPM_MADDR_RST;
      ack_q   <= 1'b0;
      dat_q   <= 32'h0000_0000;
    end else begin
      st_q    <= st_d;
      dec_q   <= dec_d;
      instr_q <= instr_d;
      rd_q    <= rd_d;
      res_q   <= res_d;
      w_q     <= w_d;
      n_q     <= n_d;
      z_q     <= z_d;
      ext_q   <= ext_d;
      fsr_q   <= fsr_d;
      bsr_q   <= bsr_d;
      maddr_q <= maddr_d;
      ack_q   <= ack_d;
      dat_q   <= dat_d;
    end
  end

  // data memory has no reset; contents are software-defined
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      dmem[mem_wa[AW-1:0]] <= mem_wd;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic [1:0]  chk_idx;
  logic [3:0]  chk_khi;
  logic [9:0]  chk_klo;
  logic        chk_neg;
  logic        q4_move;
  logic        q4_load_pointer_literal;
  assign chk_idx = dec_q.idx;
  assign chk_khi = dec_q.khi;
  assign chk_klo = instr_q[9:0];
  assign chk_neg = rd_q[7];
  assign q4_move = (st_q == lpm_pkg::ST_EXEC) && (ph == lpm_pkg::Q4) && dec_q.is_move;
  assign q4_load_pointer_literal = (ph == lpm_pkg::Q4) && dec_q.is_load_pointer_literal &&
                   ((st_q == lpm_pkg::ST_EXEC) || (st_q == lpm_pkg::ST_EXEC2));

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  load_pointer_literal_hi_write_a: assert property ((st_q == lpm_pkg::ST_EXEC && q4_load_pointer_literal && chk_idx != 2'h3)
    |=> fsr_q[$past(chk_idx)][13:10] == $past(chk_khi) && st_q == lpm_pkg::ST_WAIT2)
    else $error("pointer high bits not loaded");
  load_pointer_literal_lo_write_a: assert property ((st_q == lpm_pkg::ST_EXEC2 && q4_load_pointer_literal && chk_idx != 2'h3)
    |=> fsr_q[$past(chk_idx)][9:0] == $past(chk_klo) && st_q == lpm_pkg::ST_IDLE)
    else $error("pointer low bits not loaded");
  bad_index_a: assert property ((q4_load_pointer_literal && chk_idx == 2'h3) |=> $stable(fsr_q))
    else $error("invalid pointer index changed a pointer");
  move_to_w_a: assert property ((q4_move && !dec_q.dst) |=> w_q == $past(rd_q))
    else $error("move to working register wrong");
  move_to_f_a: assert property ((q4_move && dec_q.dst)
    |-> mem_we && mem_wd == rd_q && mem_wa == ea_w)
    else $error("move write-back wrong");
  move_flags_a: assert property (q4_move
    |=> z_q == ($past(rd_q) == 8'h00) && n_q == $past(chk_neg))
    else $error("move flags wrong");
  load_pointer_literal_flags_a: assert property (q4_load_pointer_literal |=> $stable(z_q) && $stable(n_q))
    else $error("pointer load touched flags");
  move_cycle_a: assert property ((st_q == lpm_pkg::ST_EXEC && ph == lpm_pkg::Q1 && dec_now.is_move)
    |-> ##3 (ph == lpm_pkg::Q4) ##1 (st_q == lpm_pkg::ST_IDLE))
    else $error("move did not finish in one cycle");
  bank_addr_a: assert property (dec_q.acc |-> ea_w == {bsr_q, dec_q.f})
    else $error("banked address wrong");
  ilo_addr_a: assert property ((!dec_q.acc && ext_q && dec_q.f <= 8'h5F)
    |-> ea_w == fsr_q[2] + {6'h00, dec_q.f})
    else $error("indexed literal offset address wrong");

endmodule

// ===== sim/load_pointer_move_reg_decode_bench.sv
// self-checking bench for the pointer-load / register-move executor
`timescale 1ns/10ps
`include "lpm_params.svh"
module load_pointer_move_reg_decode_bench;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [3:0]  sel_i;
  logic [7:0]  adr_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  int          n_errors;
  int          checks;
  logic [31:0] r;
  logic [3:0]  sel_v;

  typedef struct packed {
    logic        ext;
    logic [5:0]  bank;
    logic [15:0] ins;
    logic [13:0] ma;
    logic [7:0]  v;
  } lpm_row_s;

  // pointer 2 holds 14'h03AB when the table runs
  lpm_row_s    rows [8] = '{
    '{1'b0, 6'h00, 16'h5022, 14'h0022, 8'h22},
    '{1'b0, 6'h05, 16'h5140, 14'h0540, 8'h80},
    '{1'b0, 6'h00, 16'h5080, 14'h3F80, 8'h00},
    '{1'b0, 6'h2A, 16'h53FF, 14'h2AFF, 8'h7F},
    '{1'b1, 6'h00, 16'h505F, 14'h040A, 8'h91},
    '{1'b1, 6'h00, 16'h5060, 14'h3F60, 8'h13},
    '{1'b1, 6'h01, 16'h5110, 14'h0110, 8'hC3},
    '{1'b1, 6'h00, 16'h5205, 14'h03B0, 8'h00}};
  logic [13:0] ks [4] = '{14'h3FFF, 14'h2C01, 14'h03AB, 14'h1555};

  lpm_decode_top dut (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (cyc_i),
    .stb_i (stb_i),
    .we_i  (we_i),
    .sel_i (sel_i),
    .adr_i (adr_i),
    .dat_i (dat_i),
    .dat_o (dat_o),
    .ack_o (ack_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= sel_v;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    // a request that never got its answer counts against the run
    if (ack_o !== 1'b1) n_errors++;
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, r, e);
  endtask

  // poll status until masked bits match, bounded
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      wb(1'b0, `LPM_OFS_STATUS, 32'h0000_0000);
      n++;
    end while ((r & m) !== v && n < 50);
    chk("status poll", r & m, v);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    tally_and_finish();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    sel_i = 4'hF;
    sel_v = 4'hF;
    adr_i = 8'h00;
    dat_i = 32'h0000_0000;
    n_errors = 0;
    checks = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // data memory has no reset, so its window is left out here
    for (int i = 0; i < 9; i++) begin
      rc("reset value", 8'(4 * i), 32'h0000_0000);
    end
    wr(8'h40, 32'hFFFF_FFFF);
    rc("unmapped", 8'h40, 32'h0000_0000);
    $display("test reset done");

    // move 80 into W first so N stands during pointer loads
    wr(`LPM_OFS_MADDR, 32'h0000_0000);
    wr(`LPM_OFS_MDATA, 32'h0000_0080);
    wr(`LPM_OFS_INSTR, 32'h0000_5000);
    poll(32'h1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`LPM_OFS_INSTR, {16'h0, 8'hEE, 2'b00, 2'(i), ks[i][13:10]});
      poll(32'h2, 32'h2);
      chk("status wait", r, 32'h0000_000B);
      if (i < 3) rc("ptr hi", 8'(8'h14 + 4 * i), {18'h0, ks[i][13:10], 10'h000});
      wr(`LPM_OFS_INSTR, {16'h0, 6'b111100, ks[i][9:0]});
      poll(32'h3, 32'h0);
      rc("flags kept", `LPM_OFS_STATUS, 32'h0000_0008);
      for (int j = 0; j < 3; j++) begin
        rc("ptr", 8'(8'h14 + 4 * j), {18'h0, (j <= i) ? ks[j] : 14'h0000});
      end
    end
    $display("test pointer load done");

    foreach (rows[i]) begin
      wr(`LPM_OFS_CTRL, {31'h0, rows[i].ext});
      wr(`LPM_OFS_BANK, {26'h0, rows[i].bank});
      wr(`LPM_OFS_WREG, 32'h0000_00A5);
      wr(`LPM_OFS_MADDR, {18'h0, rows[i].ma});
      wr(`LPM_OFS_MDATA, {24'h0, rows[i].v});
      wr(`LPM_OFS_INSTR, {16'h0, rows[i].ins});
      poll(32'h1, 32'h0);
      rc("source", `LPM_OFS_MDATA, {24'h0, rows[i].v});
      rc("wreg", `LPM_OFS_WREG, {24'h0, rows[i].ins[9] ? 8'hA5 : rows[i].v});
      rc("flags", `LPM_OFS_STATUS, {28'h0, rows[i].v[7], rows[i].v == 8'h00, 2'b00});
    end
    $display("test move table done");

    // second instruction and memory write while busy are dropped
    wr(`LPM_OFS_CTRL, 32'h0000_0000);
    wr(`LPM_OFS_MADDR, 32'h0000_0022);
    wr(`LPM_OFS_INSTR, 32'h0000_5022);
    wr(`LPM_OFS_INSTR, 32'h0000_EE10);
    poll(32'h3, 32'h0);
    rc("ptr1 kept", 8'h18, {18'h0, ks[1]});
    rc("busy move", `LPM_OFS_WREG, 32'h0000_0022);
    wr(`LPM_OFS_INSTR, 32'h0000_5022);
    wr(`LPM_OFS_MDATA, 32'h0000_0011);
    poll(32'h1, 32'h0);
    rc("mem kept", `LPM_OFS_MDATA, 32'h0000_0022);
    $display("test busy refusal done");

    // second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc("wreg reset", `LPM_OFS_WREG, 32'h0000_0000);
    rc("ptr2 reset", `LPM_OFS_PTR2, 32'h0000_0000);
    $display("test mid reset done");

    // byte lanes: lane 0 disabled leaves the working register alone
    sel_v = 4'hE;
    wr(`LPM_OFS_WREG, 32'h0000_00FF);
    sel_v = 4'hF;
    rc("lane kept", `LPM_OFS_WREG, 32'h0000_0000);
    // an opcode that is neither move nor pointer load changes nothing
    wr(`LPM_OFS_INSTR, 32'h0000_1022);
    poll(32'h1, 32'h0);
    rc("no-op wreg", `LPM_OFS_WREG, 32'h0000_0000);
    rc("no-op flags", `LPM_OFS_STATUS, 32'h0000_0000);
    $display("test lanes and no-op done");
    tally_and_finish();
  end
endmodule
